// [hw/afsc_codec.sv]
`timescale 1ns/100ps
// Operation
// - modes 0 transparent, 1 framed, 2 escaped
// - escaped mode only on the UART port
// - delimiter, length, data, then checksum
// - start delimiter 0x7E marks frame start
// - length is big-endian count of data bytes
// - bytes before delimiter are dropped silently
// - bad frames flagged on usr_rx_bad_out after their data is passed on, status frame returned
// - escaped mode: raw 0x7E restarts frame
// - escape is 0x7D then byte xor 0x20
// - escape 0x7E, 0x7D, 0x11, 0x13
// - delimiter itself is never escaped
// - length and checksum ignore escape bytes
// - first data byte is the frame type
// - multi-byte values go most significant first
// - checksum is 0xFF minus low sum byte
// - data sum plus checksum must be 0xFF
// - zero frame id suppresses the response
module afsc_codec (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [1:0] framing_mode_select_in,
  input wire logic port_is_uart_in,
  input wire logic ser_rx_valid_in,
  input wire logic [7:0] ser_rx_data_in,
  output logic ser_tx_valid_out,
  output logic [7:0] ser_tx_data_out,
  input wire logic ser_tx_ready_in,
  output afsc_pkg::afsc_beat_t usr_rx_beat_out,
  output logic usr_rx_good_out,
  output logic usr_rx_bad_out,
  output logic usr_rx_resp_wanted_out,
  input wire logic usr_tx_valid_in,
  input wire logic [7:0] usr_tx_data_in,
  input wire logic [15:0] usr_tx_len_in,
  output logic usr_tx_ready_out
);

  typedef struct packed {
    afsc_pkg::afsc_rx_state_t rx_st;
    logic [15:0] rx_len;
    logic [15:0] rx_cnt;
    logic [7:0] rx_sum;
    logic rx_id_zero;
    afsc_pkg::afsc_beat_t rx_beat;
    logic rx_good;
    logic rx_bad;
    logic rx_resp;
    logic stat_pend;
    logic [7:0] stat_code;
    afsc_pkg::afsc_tx_state_t tx_st;
    logic tx_src_stat;
    logic [7:0] tx_code;
    logic [15:0] tx_len;
    logic [15:0] tx_cnt;
    logic [7:0] tx_sum;
  } afsc_codec_st_t;

  afsc_codec_st_t st_reg;
  afsc_codec_st_t st_next;

  logic [1:0] mode_eff;
  logic framed;
  logic esc_en;
  afsc_pkg::afsc_beat_t ub;
  logic esc_in_valid;
  logic [7:0] esc_in_data;
  logic esc_in_raw;
  logic esc_in_ready;
  logic [7:0] err_code;

  // escaped framing degrades to plain framing on a non-UART port
  always_comb begin
    mode_eff = framing_mode_select_in;
    if (framing_mode_select_in == afsc_pkg::MODE_ESCAPED && !port_is_uart_in) begin
      mode_eff = afsc_pkg::MODE_FRAMED;
    end else if (framing_mode_select_in > afsc_pkg::MODE_ESCAPED) begin
      mode_eff = afsc_pkg::MODE_TRANSPARENT;
    end
  end

  assign framed = (mode_eff != afsc_pkg::MODE_TRANSPARENT);
  assign esc_en = (mode_eff == afsc_pkg::MODE_ESCAPED);

  afsc_unescape u_unesc (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .esc_en_in(esc_en),
    .byte_valid_in(ser_rx_valid_in),
    .byte_data_in(ser_rx_data_in),
    .beat_out(ub)
  );

  afsc_escape u_esc (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .esc_en_in(esc_en),
    .in_valid_in(esc_in_valid),
    .in_data_in(esc_in_data),
    .in_raw_in(esc_in_raw),
    .in_ready_out(esc_in_ready),
    .out_valid_out(ser_tx_valid_out),
    .out_data_out(ser_tx_data_out),
    .out_ready_in(ser_tx_ready_in)
  );

  // receive path
  always_comb begin
    err_code = afsc_pkg::ERR_NONE;
    st_next = st_reg;
    st_next.rx_beat.valid = 1'b0;
    st_next.rx_beat.sof = 1'b0;
    st_next.rx_good = 1'b0;
    st_next.rx_bad = 1'b0;
    st_next.rx_resp = 1'b0;
    if (!framed) begin
      st_next.rx_st = afsc_pkg::RX_HUNT;
      st_next.rx_cnt = afsc_pkg::LEN_ZERO;
      st_next.rx_sum = afsc_pkg::ZERO_BYTE;
      if (ub.valid) begin
        st_next.rx_beat = '{valid: 1'b1, sof: 1'b0, data: ub.data};
      end
    end else if (ub.valid) begin
      if (ub.sof && (st_reg.rx_st == afsc_pkg::RX_HUNT || esc_en)) begin
        if (st_reg.rx_st != afsc_pkg::RX_HUNT) begin
          st_next.rx_bad = 1'b1;
          err_code = afsc_pkg::ERR_ABANDONED;
        end
        st_next.rx_st = afsc_pkg::RX_LEN_HI;
        st_next.rx_cnt = afsc_pkg::LEN_ZERO;
        st_next.rx_sum = afsc_pkg::ZERO_BYTE;
      end else begin
        case (st_reg.rx_st)
          afsc_pkg::RX_HUNT: begin
            st_next.rx_st = afsc_pkg::RX_HUNT;
          end
          afsc_pkg::RX_LEN_HI: begin
            st_next.rx_len[15:8] = ub.data;
            st_next.rx_st = afsc_pkg::RX_LEN_LO;
          end
          afsc_pkg::RX_LEN_LO: begin
            st_next.rx_len[7:0] = ub.data;
            if ({st_reg.rx_len[15:8], ub.data} == afsc_pkg::LEN_ZERO) begin
              // no room for a frame type: refuse rather than pass an empty frame
              st_next.rx_bad = 1'b1;
              err_code = afsc_pkg::ERR_EMPTY;
              st_next.rx_st = afsc_pkg::RX_HUNT;
            end else begin
              st_next.rx_st = afsc_pkg::RX_DATA;
            end
          end
          afsc_pkg::RX_DATA: begin
            // sof flags the frame type byte
            st_next.rx_beat = '{valid: 1'b1, sof: (st_reg.rx_cnt == afsc_pkg::POS_FRAME_TYPE), data: ub.data};
            st_next.rx_sum = afsc_pkg::csum_add(st_reg.rx_sum, ub.data);
            if (st_reg.rx_cnt == afsc_pkg::POS_FRAME_ID) begin
              st_next.rx_id_zero = (ub.data == afsc_pkg::ZERO_BYTE);
            end
            st_next.rx_cnt = st_reg.rx_cnt + afsc_pkg::CNT_ONE;
            if (st_reg.rx_cnt + afsc_pkg::CNT_ONE == st_reg.rx_len) begin
              st_next.rx_st = afsc_pkg::RX_CSUM;
            end
          end
          afsc_pkg::RX_CSUM: begin
            if (afsc_pkg::csum_add(st_reg.rx_sum, ub.data) == afsc_pkg::CSUM_GOOD) begin
              st_next.rx_good = 1'b1;
              // a one-byte frame carries no id, so no response is asked for
              st_next.rx_resp = (st_reg.rx_len > afsc_pkg::POS_FRAME_ID) && !st_reg.rx_id_zero;
            end else begin
              st_next.rx_bad = 1'b1;
              err_code = afsc_pkg::ERR_CHECKSUM;
            end
            st_next.rx_st = afsc_pkg::RX_HUNT;
            st_next.rx_cnt = afsc_pkg::LEN_ZERO;
            st_next.rx_sum = afsc_pkg::ZERO_BYTE;
          end
          default: begin
            st_next.rx_st = afsc_pkg::RX_HUNT;
          end
        endcase
      end
    end

    // transmit path
    esc_in_valid = 1'b0;
    esc_in_data = afsc_pkg::ZERO_BYTE;
    esc_in_raw = 1'b0;
    usr_tx_ready_out = 1'b0;
    case (st_reg.tx_st)
      afsc_pkg::TX_IDLE: begin
        if (!framed) begin
          esc_in_valid = usr_tx_valid_in;
          esc_in_data = usr_tx_data_in;
          esc_in_raw = 1'b1;
          usr_tx_ready_out = esc_in_ready;
        end else if (st_reg.stat_pend) begin
          // status frames go first; they are short and report host errors
          st_next.stat_pend = 1'b0;
          st_next.tx_src_stat = 1'b1;
          st_next.tx_code = st_reg.stat_code;
          st_next.tx_len = afsc_pkg::STATUS_FRAME_LEN;
          st_next.tx_st = afsc_pkg::TX_DELIM;
        end else if (usr_tx_valid_in) begin
          st_next.tx_src_stat = 1'b0;
          st_next.tx_len = usr_tx_len_in;
          st_next.tx_st = afsc_pkg::TX_DELIM;
        end
        st_next.tx_cnt = afsc_pkg::LEN_ZERO;
        st_next.tx_sum = afsc_pkg::ZERO_BYTE;
      end
      afsc_pkg::TX_DELIM: begin
        esc_in_valid = 1'b1;
        esc_in_data = afsc_pkg::DELIM_BYTE;
        esc_in_raw = 1'b1;
        if (esc_in_ready) begin
          st_next.tx_st = afsc_pkg::TX_LEN_HI;
        end
      end
      afsc_pkg::TX_LEN_HI: begin
        esc_in_valid = 1'b1;
        esc_in_data = st_reg.tx_len[15:8];
        if (esc_in_ready) begin
          st_next.tx_st = afsc_pkg::TX_LEN_LO;
        end
      end
      afsc_pkg::TX_LEN_LO: begin
        esc_in_valid = 1'b1;
        esc_in_data = st_reg.tx_len[7:0];
        if (esc_in_ready) begin
          st_next.tx_st = (st_reg.tx_len == afsc_pkg::LEN_ZERO) ? afsc_pkg::TX_CSUM : afsc_pkg::TX_DATA;
        end
      end
      afsc_pkg::TX_DATA: begin
        if (st_reg.tx_src_stat) begin
          esc_in_valid = 1'b1;
          esc_in_data = (st_reg.tx_cnt == afsc_pkg::POS_FRAME_TYPE) ? afsc_pkg::STATUS_FRAME_TYPE : st_reg.tx_code;
        end else begin
          esc_in_valid = usr_tx_valid_in;
          esc_in_data = usr_tx_data_in;
          usr_tx_ready_out = esc_in_ready;
        end
        if (esc_in_valid && esc_in_ready) begin
          st_next.tx_sum = afsc_pkg::csum_add(st_reg.tx_sum, esc_in_data);
          st_next.tx_cnt = st_reg.tx_cnt + afsc_pkg::CNT_ONE;
          if (st_reg.tx_cnt + afsc_pkg::CNT_ONE == st_reg.tx_len) begin
            st_next.tx_st = afsc_pkg::TX_CSUM;
          end
        end
      end
      afsc_pkg::TX_CSUM: begin
        esc_in_valid = 1'b1;
        esc_in_data = afsc_pkg::CSUM_BASE - st_reg.tx_sum;
        if (esc_in_ready) begin
          st_next.tx_st = afsc_pkg::TX_IDLE;
        end
      end
      default: begin
        st_next.tx_st = afsc_pkg::TX_IDLE;
      end
    endcase

    // a new failure outranks the clear of the pending flag; latest cause kept
    if (err_code != afsc_pkg::ERR_NONE) begin
      st_next.stat_pend = 1'b1;
      st_next.stat_code = err_code;
    end
    if (!framed) begin
      st_next.stat_pend = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_reg <= '0;
      st_reg.rx_st <= afsc_pkg::RX_HUNT;
      st_reg.tx_st <= afsc_pkg::TX_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign usr_rx_beat_out = st_reg.rx_beat;
  assign usr_rx_good_out = st_reg.rx_good;
  assign usr_rx_bad_out = st_reg.rx_bad;
  assign usr_rx_resp_wanted_out = st_reg.rx_resp;

endmodule : afsc_codec

// [hw/afsc_escape.sv]
`timescale 1ns/100ps
module afsc_escape (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic esc_en_in,
  input wire logic in_valid_in,
  input wire logic [7:0] in_data_in,
  input wire logic in_raw_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [7:0] out_data_out,
  input wire logic out_ready_in
);

  typedef struct packed {
    logic out_valid;
    logic [7:0] out_data;
    logic pend;
    logic [7:0] pend_data;
  } afsc_esc_st_t;

  afsc_esc_st_t st_reg;
  afsc_esc_st_t st_next;
  logic take;

  // a pending second half blocks new input so the pair never splits
  assign in_ready_out = !st_reg.pend && (!st_reg.out_valid || out_ready_in);
  assign take = in_valid_in && in_ready_out;

  always_comb begin
    st_next = st_reg;
    if (st_reg.out_valid && out_ready_in) begin
      if (st_reg.pend) begin
        st_next.out_data = st_reg.pend_data ^ afsc_pkg::ESC_XOR;
        st_next.pend = 1'b0;
      end else begin
        st_next.out_valid = 1'b0;
      end
    end
    if (take) begin
      st_next.out_valid = 1'b1;
      if (esc_en_in && !in_raw_in && afsc_pkg::needs_escape(in_data_in)) begin
        st_next.out_data = afsc_pkg::ESC_BYTE;
        st_next.pend = 1'b1;
        st_next.pend_data = in_data_in;
      end else begin
        st_next.out_data = in_data_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_valid_out = st_reg.out_valid;
  assign out_data_out = st_reg.out_data;

endmodule : afsc_escape

// [hw/afsc_pkg.sv]
package afsc_pkg;

  // framing bytes
  localparam logic [7:0] DELIM_BYTE = 8'h7E;
  localparam logic [7:0] ESC_BYTE = 8'h7D;
  localparam logic [7:0] XON_BYTE = 8'h11;
  localparam logic [7:0] XOFF_BYTE = 8'h13;
  localparam logic [7:0] ESC_XOR = 8'h20;
  localparam logic [7:0] CSUM_GOOD = 8'hFF;
  localparam logic [7:0] CSUM_BASE = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // framing_mode_select encodings
  localparam logic [1:0] MODE_TRANSPARENT = 2'h0;
  localparam logic [1:0] MODE_FRAMED = 2'h1;
  localparam logic [1:0] MODE_ESCAPED = 2'h2;

  // status frame sent back on a bad incoming frame: type byte then cause byte
  localparam logic [7:0] STATUS_FRAME_TYPE = 8'hC0;
  localparam logic [15:0] STATUS_FRAME_LEN = 16'h0002;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_CHECKSUM = 8'h01;
  localparam logic [7:0] ERR_ABANDONED = 8'h02;
  localparam logic [7:0] ERR_EMPTY = 8'h03;

  // data positions inside frame data (0 = frame type)
  localparam logic [15:0] POS_FRAME_TYPE = 16'h0000;
  localparam logic [15:0] POS_FRAME_ID = 16'h0001;
  localparam logic [15:0] LEN_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  typedef struct packed {
    logic valid;
    logic sof;
    logic [7:0] data;
  } afsc_beat_t;

  typedef enum logic [4:0] {
    RX_HUNT = 5'b00001,
    RX_LEN_HI = 5'b00010,
    RX_LEN_LO = 5'b00100,
    RX_DATA = 5'b01000,
    RX_CSUM = 5'b10000
  } afsc_rx_state_t;

  typedef enum logic [5:0] {
    TX_IDLE = 6'b000001,
    TX_DELIM = 6'b000010,
    TX_LEN_HI = 6'b000100,
    TX_LEN_LO = 6'b001000,
    TX_DATA = 6'b010000,
    TX_CSUM = 6'b100000
  } afsc_tx_state_t;

  function automatic logic needs_escape(input logic [7:0] b);
    needs_escape = (b == DELIM_BYTE) || (b == ESC_BYTE) || (b == XON_BYTE) || (b == XOFF_BYTE);
  endfunction : needs_escape

  function automatic logic [7:0] csum_add(input logic [7:0] acc, input logic [7:0] b);
    csum_add = acc + b;
  endfunction : csum_add

endpackage : afsc_pkg

// [hw/afsc_unescape.sv]
`timescale 1ns/100ps
module afsc_unescape (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic esc_en_in,
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_data_in,
  output afsc_pkg::afsc_beat_t beat_out
);

  typedef struct packed {
    logic pend;
    afsc_pkg::afsc_beat_t beat;
  } afsc_unesc_st_t;

  afsc_unesc_st_t st_reg;
  afsc_unesc_st_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.beat.valid = 1'b0;
    st_next.beat.sof = 1'b0;
    if (byte_valid_in) begin
      if (byte_data_in == afsc_pkg::DELIM_BYTE) begin
        // a raw delimiter always marks a frame start, even right after an escape
        st_next.beat = '{valid: 1'b1, sof: 1'b1, data: byte_data_in};
        st_next.pend = 1'b0;
      end else if (esc_en_in && st_reg.pend) begin
        st_next.beat = '{valid: 1'b1, sof: 1'b0, data: byte_data_in ^ afsc_pkg::ESC_XOR};
        st_next.pend = 1'b0;
      end else if (esc_en_in && byte_data_in == afsc_pkg::ESC_BYTE) begin
        st_next.pend = 1'b1;
      end else begin
        st_next.beat = '{valid: 1'b1, sof: 1'b0, data: byte_data_in};
      end
    end
    if (!esc_en_in) begin
      st_next.pend = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign beat_out = st_reg.beat;

endmodule : afsc_unescape

// [tb/afsc_codec_props.sv]
`timescale 1ns/100ps
module afsc_codec_props (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [1:0] framing_mode_select_in,
  input wire logic port_is_uart_in,
  input wire logic ser_rx_valid_in,
  input wire logic [7:0] ser_rx_data_in,
  input wire logic ser_tx_valid_out,
  input wire logic [7:0] ser_tx_data_out,
  input wire logic ser_tx_ready_in,
  input wire afsc_pkg::afsc_beat_t usr_rx_beat_out,
  input wire logic usr_rx_good_out,
  input wire logic usr_rx_bad_out,
  input wire logic usr_rx_resp_wanted_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  wire logic m0 = framing_mode_select_in == afsc_pkg::MODE_TRANSPARENT;
  wire logic esc_m = framing_mode_select_in == afsc_pkg::MODE_ESCAPED && port_is_uart_in;
  wire logic tx_esc = ser_tx_valid_out && ser_tx_ready_in && ser_tx_data_out == afsc_pkg::ESC_BYTE;
  wire logic esc_pair = ser_tx_data_out == 8'h5E || ser_tx_data_out == 8'h5D
    || ser_tx_data_out == 8'h31 || ser_tx_data_out == 8'h33;

  a_reset_quiet: assert property ($fell(rst_in) |-> !ser_tx_valid_out && !usr_rx_beat_out.valid
    && !usr_rx_good_out && !usr_rx_bad_out) else $error("outputs active after reset");
  a_transp_pass: assert property ((ser_rx_valid_in && m0) ##1 m0 ##1 m0 |-> usr_rx_beat_out.valid
    && !usr_rx_beat_out.sof && usr_rx_beat_out.data == $past(ser_rx_data_in, 2))
    else $error("transparent byte not passed through");
  a_sof_framed: assert property (usr_rx_beat_out.sof |-> usr_rx_beat_out.valid
    && $past(framing_mode_select_in, 2) != afsc_pkg::MODE_TRANSPARENT) else $error("sof outside framing");
  a_no_flow_bytes: assert property (ser_tx_valid_out && esc_m && $past(esc_m) |->
    ser_tx_data_out != afsc_pkg::XON_BYTE && ser_tx_data_out != afsc_pkg::XOFF_BYTE)
    else $error("flow byte sent unescaped");
  a_esc_follow: assert property (tx_esc && esc_m |=> ##[0:1] (ser_tx_valid_out && esc_pair))
    else $error("escape byte not followed by xored byte");
  a_tx_hold: assert property (ser_tx_valid_out && !ser_tx_ready_in |=>
    ser_tx_valid_out && $stable(ser_tx_data_out)) else $error("tx byte dropped while stalled");
  a_good_bad_excl: assert property (!(usr_rx_good_out && usr_rx_bad_out))
    else $error("good and bad together");
  a_resp_good: assert property (usr_rx_resp_wanted_out |-> usr_rx_good_out)
    else $error("response wanted without good frame");
  a_good_cause: assert property (usr_rx_good_out |-> $past(ser_rx_valid_in, 2))
    else $error("good pulse without checksum byte");

  c_good: cover property (usr_rx_good_out && usr_rx_resp_wanted_out);
  c_bad: cover property (usr_rx_bad_out);
  c_esc: cover property (tx_esc && esc_m);
endmodule : afsc_codec_props

bind afsc_codec afsc_codec_props u_props (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
  .framing_mode_select_in(framing_mode_select_in), .port_is_uart_in(port_is_uart_in),
  .ser_rx_valid_in(ser_rx_valid_in), .ser_rx_data_in(ser_rx_data_in), .ser_tx_valid_out(ser_tx_valid_out),
  .ser_tx_data_out(ser_tx_data_out), .ser_tx_ready_in(ser_tx_ready_in), .usr_rx_beat_out(usr_rx_beat_out),
  .usr_rx_good_out(usr_rx_good_out), .usr_rx_bad_out(usr_rx_bad_out),
  .usr_rx_resp_wanted_out(usr_rx_resp_wanted_out));

// [tb/afsc_host_model.sv]
`timescale 1ns/100ps
module afsc_host_model (
  input wire logic clk_in,
  input wire logic slow_in,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out
);
  logic [7:0] send_q[$];
  logic [7:0] got_q[$];
  logic [1:0] phase = 2'h0;
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    tx_ready_out = 1'b1;
  end
  always @(posedge clk_in) begin
    phase <= phase + 2'h1;
    if (tx_valid_in && tx_ready_out) begin
      // every frame is kept whatever its type; an unknown type is no failure here
      got_q.push_back(tx_data_in);
    end
    // slow host takes one byte in four
    tx_ready_out <= !slow_in || phase == 2'h3;
    if (send_q.size() > 0) begin
      rx_valid_out <= 1'b1;
      rx_data_out <= send_q.pop_front();
    end else begin
      rx_valid_out <= 1'b0;
      rx_data_out <= ~rx_data_out; // idle line must not look like a held byte
    end
  end
endmodule : afsc_host_model

// [tb/test_api_serial_frame_codec.sv]
`timescale 1ns/100ps
module test_api_serial_frame_codec;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [1:0] mode = 2'h0;
  logic uart = 1'b1;
  logic slow = 1'b0;
  logic utv = 1'b0;
  logic [7:0] utd = 8'h00;
  logic [15:0] utl = 16'h0000;
  logic rxv, txv, txr, good, bad, resp, utr;
  logic [7:0] rxd, txd;
  afsc_pkg::afsc_beat_t beat;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int good_n = 0;
  int bad_n = 0;
  int resp_n = 0;
  logic [8:0] beats[$];
  logic [7:0] wq[$];
  always #4 clk_sys_in = ~clk_sys_in;
  afsc_codec uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .framing_mode_select_in(mode),
    .port_is_uart_in(uart), .ser_rx_valid_in(rxv), .ser_rx_data_in(rxd), .ser_tx_valid_out(txv),
    .ser_tx_data_out(txd), .ser_tx_ready_in(txr), .usr_rx_beat_out(beat), .usr_rx_good_out(good),
    .usr_rx_bad_out(bad), .usr_rx_resp_wanted_out(resp), .usr_tx_valid_in(utv),
    .usr_tx_data_in(utd), .usr_tx_len_in(utl), .usr_tx_ready_out(utr));
  afsc_host_model host (.clk_in(clk_sys_in), .slow_in(slow), .rx_valid_out(rxv), .rx_data_out(rxd),
    .tx_valid_in(txv), .tx_data_in(txd), .tx_ready_out(txr));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (beat.valid === 1'b1) begin
      beats.push_back({beat.sof, beat.data});
    end
    good_n += (good === 1'b1);
    bad_n += (bad === 1'b1);
    resp_n += (resp === 1'b1);
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic put(input logic [7:0] b, input logic esc);
    if (esc && (b == 8'h7E || b == 8'h7D || b == 8'h11 || b == 8'h13)) begin
      wq.push_back(8'h7D);
      wq.push_back(b ^ 8'h20);
    end else begin
      wq.push_back(b);
    end
  endtask : put

  // skew spoils the checksum on purpose
  task automatic mk(input logic [7:0] d[$], input logic esc, input logic [7:0] skew);
    logic [15:0] n;
    logic [7:0] s;
    n = 16'(d.size());
    s = 8'h00;
    wq.push_back(8'h7E);
    put(n[15:8], esc);
    put(n[7:0], esc);
    foreach (d[i]) begin
      s = s + d[i];
      put(d[i], esc);
    end
    put(8'hFF - s + skew, esc);
  endtask : mk

  task automatic clr();
    beats.delete();
    host.got_q.delete();
    wq.delete();
    good_n = 0;
    bad_n = 0;
    resp_n = 0;
  endtask : clr

  task automatic play(input int n);
    foreach (wq[i]) host.send_q.push_back(wq[i]);
    wq.delete();
    repeat (n) @(posedge clk_sys_in);
  endtask : play

  task automatic exp_beats(input logic [8:0] e[$]);
    check(16'(beats.size()), 16'(e.size()));
    foreach (e[i]) check(16'(beats[i]), 16'(e[i]));
  endtask : exp_beats

  task automatic cmp_tx();
    check(16'(host.got_q.size()), 16'(wq.size()));
    foreach (wq[i]) check(16'(host.got_q[i]), 16'(wq[i]));
  endtask : cmp_tx

  task automatic send_user(input logic [15:0] n, input logic [7:0] d[$]);
    int k;
    foreach (d[i]) begin
      utv <= 1'b1;
      utd <= d[i];
      utl <= n;
      k = 0;
      do begin
        @(posedge clk_sys_in);
        k++;
      end while (utr !== 1'b1 && k < 80);
      // a byte never taken within the limit counts as a mismatch
      check(16'(utr === 1'b1), 16'h0001);
    end
    utv <= 1'b0;
    repeat (60) @(posedge clk_sys_in);
  endtask : send_user

  task automatic t_transparent();
    clr();
    wq = '{8'h7E, 8'h13, 8'hA5};
    play(10);
    exp_beats('{9'h07E, 9'h013, 9'h0A5});
    send_user(16'h0000, '{8'h7E});
    wq = '{8'h7E};
    cmp_tx();
    $display("test transparent done");
  endtask : t_transparent

  task automatic t_framed_rx();
    mode <= 2'h1;
    clr();
    wq = '{8'h55, 8'h7D};
    mk('{8'h08, 8'h01}, 1'b0, 8'h00);
    mk('{8'h08, 8'h00}, 1'b0, 8'h01);
    mk('{8'h08, 8'h00}, 1'b0, 8'h00);
    play(60);
    exp_beats('{9'h108, 9'h001, 9'h108, 9'h000, 9'h108, 9'h000});
    check(16'(good_n), 16'h0002);
    check(16'(bad_n), 16'h0001);
    check(16'(resp_n), 16'h0001);
    mk('{8'hC0, 8'h01}, 1'b0, 8'h00);
    cmp_tx();
    $display("test framed_rx done");
  endtask : t_framed_rx

  task automatic t_escaped_rx();
    mode <= 2'h2;
    slow <= 1'b1;
    clr();
    mk('{8'h08, 8'h11}, 1'b1, 8'h00);
    wq = {wq, 8'h7E, 8'h00, 8'h05, 8'h08, 8'h01};
    mk('{8'h08, 8'h01}, 1'b1, 8'h00);
    play(90);
    exp_beats('{9'h108, 9'h011, 9'h108, 9'h001, 9'h108, 9'h001});
    check(16'(good_n), 16'h0002);
    check(16'(bad_n), 16'h0001);
    check(16'(resp_n), 16'h0002);
    mk('{8'hC0, 8'h02}, 1'b1, 8'h00);
    cmp_tx();
    $display("test escaped_rx done");
  endtask : t_escaped_rx

  task automatic t_escaped_tx();
    clr();
    send_user(16'h0002, '{8'h7E, 8'h13});
    mk('{8'h7E, 8'h13}, 1'b1, 8'h00);
    cmp_tx();
    slow <= 1'b0;
    $display("test escaped_tx done");
  endtask : t_escaped_tx

  task automatic t_non_uart();
    uart <= 1'b0;
    clr();
    // a zero length frame follows; it must be refused with its own cause
    wq = '{8'h7E, 8'h00, 8'h01, 8'h7D, 8'h82, 8'h7E, 8'h00, 8'h00};
    play(30);
    exp_beats('{9'h17D});
    check(16'(good_n), 16'h0001);
    check(16'(bad_n), 16'h0001);
    check(16'(resp_n), 16'h0000);
    send_user(16'h0001, '{8'h11});
    mk('{8'hC0, 8'h03}, 1'b0, 8'h00);
    mk('{8'h11}, 1'b0, 8'h00);
    cmp_tx();
    $display("test non_uart done");
  endtask : t_non_uart

  initial begin
    repeat (8) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    t_transparent();
    t_framed_rx();
    t_escaped_rx();
    t_escaped_tx();
    t_non_uart();
    end_sim();
  end
endmodule : test_api_serial_frame_codec
